//--- bench/tb_top.sv
// tb_top: self-checking bench for the clock and power manager register block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cpm_pkg::*;
  typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} cpm_row_t;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic waitreq;
  logic slow_q = 1'b0;
  logic main_q = 1'b0;
  logic pll_q = 1'b0;
  logic [3:0] div_q = 4'h0;
  logic cpu_en;
  logic usb_en;
  logic pll_ref;
  logic [31:0] per_en;
  logic [31:0] q;
  logic mclk;
  logic mclk_d = 1'b0;
  logic [2:0] pck_out;
  int mtog = 0;
  int m0 = 0;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  // write then read back; offsets are byte addresses of the register map
  cpm_row_t rows [0:22] = '{
    '{8'h10, 32'h0000_0110, 8'h18, 32'h0000_0110},
    '{8'h14, 32'h0000_0010, 8'h18, 32'h0000_0100},
    '{8'h10, 32'h0000_0003, 8'h18, 32'h0000_0100},
    '{8'h14, 32'h0000_0000, 8'h18, 32'h0000_0100},
    '{8'h10, 32'hffff_fffc, 8'h18, 32'hffff_fffc},
    '{8'h14, 32'hffff_ffff, 8'h18, 32'h0000_0000},
    '{8'h18, 32'hffff_ffff, 8'h18, 32'h0000_0000},
    '{8'h00, 32'h0000_0780, 8'h08, 32'h0000_0781},
    '{8'h04, 32'h0000_0001, 8'h08, 32'h0000_0780},
    '{8'h04, 32'h0000_0700, 8'h08, 32'h0000_0080},
    '{8'h00, 32'h0000_0001, 8'h08, 32'h0000_0081},
    '{8'h04, 32'h0000_0080, 8'h08, 32'h0000_0001},
    '{8'h0c, 32'hffff_ffff, 8'h0c, 32'h0000_0000},
    '{8'h30, 32'h0000_0001, 8'h30, 32'h0000_0001},
    '{8'h30, 32'h0000_0011, 8'h30, 32'h0000_0011},
    '{8'h30, 32'h0000_0012, 8'h30, 32'h0000_0011},
    '{8'h30, 32'h0000_001d, 8'h30, 32'h0000_0011},
    '{8'h40, 32'h0000_0015, 8'h40, 32'h0000_0015},
    '{8'h44, 32'h0000_0003, 8'h44, 32'h0000_0003},
    '{8'h48, 32'h0000_0018, 8'h48, 32'h0000_0018},
    '{8'h48, 32'h0000_001e, 8'h48, 32'h0000_0018},
    '{8'h2c, 32'h1001_0a02, 8'h2c, 32'h1001_0a02},
    '{8'h2c, 32'h3001_0a02, 8'h2c, 32'h1001_0a02}
  };
  logic [7:0] rst_a [0:7] = '{8'h08, 8'h18, 8'h20, 8'h24, 8'h2c, 8'h30, 8'h40, 8'h68};
  logic [31:0] rst_v [0:7] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h3f00, 32'h0, 32'h0, 32'h8};

  cpm_top i_cpm_top (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq),
    .i_slow_clk(slow_q), .i_crystal_in(main_q), .i_pll_clk(pll_q),
    .o_cpu_clk_en(cpu_en), .o_usb_clk_en(usb_en), .o_periph_clk_en(per_en),
    .o_master_clk(mclk), .o_ext_clock_out(pck_out), .o_pll_ref_en(pll_ref)
  );

  // count master clock edges seen by the bench
  always @(posedge i_core_clk) begin
    mclk_d <= mclk;
    if (mclk !== mclk_d) mtog++;
  end

  // 200 MHz core clock
  always #2.5 i_core_clk = ~i_core_clk;

  // source clocks: slow 1/16, crystal 1/4, pll 1/8 of core rate, all under a third of it
  always @(posedge i_core_clk) begin
    div_q <= div_q + 4'h1;
    slow_q <= (div_q[2:0] == 3'h7) ? ~slow_q : slow_q;
    main_q <= div_q[0] ? ~main_q : main_q;
    pll_q <= (div_q[1:0] == 2'h3) ? ~pll_q : pll_q;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one avalon transfer; entered just after a rising edge, holds until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    do begin
      @(posedge i_core_clk);
    end while (waitreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    chk("waitrequest", {31'h0, waitreq}, 32'h0);
    @(posedge i_core_clk);
  endtask

  // read one bit of a register until it reaches v or the read budget runs out
  task automatic poll(input logic [7:0] a, input int b, input logic v, input int lim);
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h0);
      k++;
    end while (q[b] !== v && k < lim);
    chk("polled bit", {31'h0, q[b]}, {31'h0, v});
  endtask

  task automatic reset_regs();
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, rst_a[i], 32'h0);
      chk("reset value", q, rst_v[i]);
    end
  endtask

  initial begin
    repeat (4) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    reset_regs();
    foreach (rows[i]) begin
      bus(1'b1, rows[i].wa, rows[i].wd);
      bus(1'b0, rows[i].ra, 32'h0);
      chk("row readback", q, rows[i].ex);
    end
    // oscillator start-up: count 2 means 16 slow ticks, far more than the early look
    bus(1'b1, 8'h20, 32'h0000_0201);
    repeat (100) @(posedge i_core_clk);
    bus(1'b0, 8'h68, 32'h0);
    chk("early osc stable", {31'h0, q[0]}, 32'h0);
    poll(8'h68, 0, 1'b1, 200);
    poll(8'h24, 16, 1'b1, 200);
    // 16 slow periods of 16 core cycles hold 64 crystal cycles; allow edge jitter of two
    chk("freq count in range", {31'h0, q[15:0] >= 16'd62 && q[15:0] <= 16'd66}, 32'h1);
    bus(1'b1, 8'h20, 32'h0);
    repeat (4) @(posedge i_core_clk);
    poll(8'h68, 0, 1'b0, 1);
    poll(8'h24, 16, 1'b0, 1);
    bus(1'b1, 8'h20, 32'h0000_0002);
    poll(8'h68, 0, 1'b1, 1);
    // lock drops on a pll write and returns after the lock wait
    bus(1'b1, 8'h2c, 32'h0001_0402);
    poll(8'h68, 2, 1'b0, 1);
    poll(8'h68, 2, 1'b1, 100);
    chk("pll ref enable", {31'h0, pll_ref}, 32'h1);
    bus(1'b1, 8'h2c, 32'h0001_0400);
    chk("pll ref off", {31'h0, pll_ref}, 32'h0);
    // prescaler change from code 4 to 0 on the main source clears master ready until the switch settles
    bus(1'b1, 8'h30, 32'h0000_0001);
    poll(8'h68, 3, 1'b0, 1);
    poll(8'h68, 3, 1'b1, 200);
    // master on the PLL runs from main clock until lock returns, then switches and settles again
    m0 = mtog;
    bus(1'b1, 8'h2c, 32'h0001_0402);
    bus(1'b1, 8'h30, 32'h0000_0003);
    poll(8'h68, 3, 1'b1, 1);
    poll(8'h68, 3, 1'b0, 100);
    poll(8'h68, 3, 1'b1, 400);
    chk("master clock toggles", {31'h0, mtog > m0}, 32'h1);
    chk("cpu enable", {31'h0, cpu_en}, 32'h1);
    chk("usb enable", {31'h0, usb_en}, 32'h0);
    bus(1'b1, 8'h10, 32'h0000_0110);
    chk("periph enables", per_en, 32'h0000_0110);
    bus(1'b1, 8'h04, 32'h0000_0001);
    chk("cpu idle", {31'h0, cpu_en}, 32'h0);
    // second reset in mid-run: bus held off and registers back to reset values
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    chk("reset waitrequest", {31'h0, waitreq}, 32'h1);
    chk("reset cpu enable", {31'h0, cpu_en}, 32'h1);
    chk("reset periph enables", per_en, 32'h0);
    chk("reset ext outputs", {29'h0, pck_out}, 32'h0);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    reset_regs();
    end_of_test();
  end
endmodule
`default_nettype wire

//--- verilog/cpm_clk_div.sv
// cpm_clk_div: source select, power-of-two prescaler and an enable gate that forces low at once, for one derived clock
`timescale 1ns/100ps
`default_nettype none
module cpm_clk_div (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // sources, already synchronised tick strobes
  input wire logic i_slow_tick,
  input wire logic i_main_tick,
  input wire logic i_pll_tick,
  // configuration
  input wire logic [1:0] i_src,
  input wire logic [2:0] i_clock_scaler_code,
  input wire logic i_enable,
  // outputs
  output logic o_clk,
  output logic o_ready
);
  import cpm_pkg::*;

  typedef struct packed {
    logic [5:0] div;
    logic [7:0] settle;
    logic [1:0] src;
    logic [2:0] clock_scaler_code;
    logic clk;
    logic ready;
  } cpm_div_t;

  cpm_div_t s_q, s_d;
  logic tick;
  logic [6:0] half;

  // selected source; reserved code was already blocked upstream
  always_comb begin
    unique case (s_q.src)
      CPM_SRC_SLOW: tick = i_slow_tick;
      CPM_SRC_MAIN: tick = i_main_tick;
      CPM_SRC_PLL: tick = i_pll_tick;
      default: tick = 1'b0;
    endcase
  end

  assign half = 7'(1) << s_q.clock_scaler_code;

  // toggle only on divider wrap while enabled; a disable forces the output low at once, which can cut a high half period short
  always_comb begin
    s_d = s_q;
    if ((i_src != s_q.src) || (i_clock_scaler_code != s_q.clock_scaler_code)) begin
      s_d.src = i_src;
      s_d.clock_scaler_code = i_clock_scaler_code;
      s_d.ready = 1'b0;
      s_d.settle = CPM_SWITCH_CYC;
      s_d.div = '0;
    end else if (!i_enable) begin
      // a disabled output holds low and restarts its settle count, so ready means enabled and settled
      s_d.clk = 1'b0;
      s_d.ready = 1'b0;
      s_d.settle = CPM_SWITCH_CYC;
      s_d.div = '0;
    end else if (tick) begin
      if (({1'b0, s_q.div} + 7'd1 >= half) || (s_q.clock_scaler_code == 3'h0)) begin
        s_d.div = '0;
        s_d.clk = i_enable ? ~s_q.clk : 1'b0;
      end else begin
        s_d.div = s_q.div + 6'd1;
      end
      if (s_q.settle != 8'd0) begin
        s_d.settle = s_q.settle - 8'd1;
      end else begin
        s_d.ready = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_clk = s_q.clk;
  assign o_ready = s_q.ready;
endmodule
`default_nettype wire

//--- verilog/cpm_pkg.sv
// cpm_pkg: register map, field layout, reset values and timing counts of the clock and power manager
package cpm_pkg;
  // register byte offsets
  localparam logic [7:0] CPM_SYS_SET_OFF = 8'h00;
  localparam logic [7:0] CPM_SYS_CLR_OFF = 8'h04;
  localparam logic [7:0] CPM_SYS_STATE_OFF = 8'h08;
  localparam logic [7:0] CPM_PER_SET_OFF = 8'h10;
  localparam logic [7:0] CPM_PER_CLR_OFF = 8'h14;
  localparam logic [7:0] CPM_PER_STATE_OFF = 8'h18;
  localparam logic [7:0] CPM_OSC_CTRL_OFF = 8'h20;
  localparam logic [7:0] CPM_FREQ_OFF = 8'h24;
  localparam logic [7:0] CPM_PLL_CFG_OFF = 8'h2c;
  localparam logic [7:0] CPM_MCK_CFG_OFF = 8'h30;
  localparam logic [7:0] CPM_PCK0_OFF = 8'h40;
  localparam logic [7:0] CPM_PCK1_OFF = 8'h44;
  localparam logic [7:0] CPM_PCK2_OFF = 8'h48;
  localparam logic [7:0] CPM_STATUS_OFF = 8'h68;
  // system clock bits
  localparam int CPM_CPU_BIT = 0;
  localparam int CPM_USB_BIT = 7;
  localparam int CPM_PCK_LSB = 8;
  localparam int CPM_NUM_PCK = 3;
  // status bits
  localparam int CPM_ST_OSC = 0;
  localparam int CPM_ST_LOCK = 2;
  localparam int CPM_ST_MCK = 3;
  localparam int CPM_ST_PCK_LSB = 8;
  // implemented peripheral positions (2..31); 0 and 1 are not implemented
  localparam logic [31:0] CPM_PER_IMPL = 32'hffff_fffc;
  // reset values
  localparam logic [31:0] CPM_PLL_RST = 32'h0000_3f00;
  localparam logic [11:0] CPM_SYS_RST = 12'h001;
  // slow clock timing
  localparam int CPM_OSC_UNIT = 8;
  localparam int CPM_FREQ_WINDOW = 16;
  localparam int CPM_SCALER_MAX = 64;
  // settle time of a clock switch in cycles of the selected source (prescaler worst case)
  localparam logic [7:0] CPM_SWITCH_CYC = 8'd64;
  localparam logic [1:0] CPM_SRC_SLOW = 2'h0;
  localparam logic [1:0] CPM_SRC_MAIN = 2'h1;
  localparam logic [1:0] CPM_SRC_RSV = 2'h2;
  localparam logic [1:0] CPM_SRC_PLL = 2'h3;
  localparam logic [2:0] CPM_CLOCK_SCALER_CODE_RSV = 3'h7;
  localparam logic [1:0] CPM_USB_CLOCK_RATIO_RSV = 2'h3;
endpackage

//--- verilog/cpm_top.sv
// cpm_top: clock and power manager register block on an Avalon-MM slave
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE1: system state bit 0 reads 1 while the processor clock runs.
// RULE2: system state bit 7 reflects the USB 48 MHz clock enable.
// RULE3: system state bits 8..10 read each programmable output enable.
// RULE4: writing 1 to peripheral set bits 2..31 enables that clock; 0 no effect.
// RULE5: writes to unimplemented peripheral positions are ignored.
// RULE6: writing 1 to peripheral clear bit stops that clock; 0 no effect.
// RULE7: peripheral state reads 1 per enabled implemented peripheral.
// RULE8: oscillator stable only after start-up interval; software keeps bypass 0.
// RULE9: bypass sets oscillator stable at once; clock taken from crystal input.
// RULE10: clearing both enable and bypass drops oscillator stable.
// RULE11: start-up interval is start-up count times 8 slow cycles.
// RULE12: frequency field counts main cycles within 16 slow periods.
// RULE13: frequency valid reads 1 only after oscillator on and count done.
// RULE14: reference divider: 0 gives zero, 1 passes, 2..255 divides.
// RULE15: after a PLL write, lock rises after lock wait count slow cycles.
// RULE16: software writes band codes 00 or 10 only.
// RULE17: factor 0 stops the PLL; else output is input times factor plus one.
// RULE18: USB ratio 00 pass, 01 half, 10 quarter, 11 reserved.
// RULE19: master source 00 slow, 01 main, 11 PLL; 10 reserved.
// RULE20: master prescaler codes 0..6 divide by 1..64; 7 reserved. Here codes 0..6 divide the source by 2..128.
// RULE21: programmable outputs use the same source encoding.
// RULE22: each programmable output has its own power-of-two prescaler.
// RULE23: master ready drops on source or prescaler change, rises when stable.
// RULE24: while PLL unlocked, master runs from main clock.
// RULE25: programmable output ready flag follows enable; reconfigure only disabled.
// RULE26: writing processor bit in system clear stops processor clock.
// RULE27: status bits update on the cycle after an enable or disable write.
// RULE28: reserved source or prescaler codes keep the current selection.
module cpm_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // avalon-mm slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // clock sources from pins, asynchronous to the core clock
  input wire logic i_slow_clk,
  input wire logic i_crystal_in,
  input wire logic i_pll_clk,
  // gated clock outputs
  output logic o_cpu_clk_en,
  output logic o_usb_clk_en,
  output logic [31:0] o_periph_clk_en,
  output logic o_master_clk,
  output logic [2:0] o_ext_clock_out,
  output logic o_pll_ref_en
);
  import cpm_pkg::*;

  typedef struct packed {
    logic pll_ref;
    logic [2:0] slow_s;
    logic [2:0] main_s;
    logic [2:0] pll_s;
    logic [11:0] sys_en;
    logic [31:0] per_en;
    logic [7:0] osc_count;
    logic osc_on;
    logic osc_skip;
    logic osc_stable;
    logic [10:0] osc_timer;
    logic [4:0] win_cnt;
    logic [15:0] freq_acc;
    logic [15:0] freq_cnt;
    logic freq_valid;
    logic [31:0] pll_cfg;
    logic [7:0] lock_timer;
    logic pll_locked;
    logic [1:0] mck_src;
    logic [2:0] mck_clock_scaler_code;
    logic [2:0][4:0] pck_cfg;
    logic ack;
    logic [31:0] rdata;
  } cpm_state_t;

  cpm_state_t s_q, s_d;
  logic rst_n;
  logic [1:0] rst_sync_q;
  logic slow_tick, main_tick, pll_tick;
  logic wr, rd;
  logic [1:0] mck_eff_src;
  logic mck_clk, mck_ready;
  logic [2:0] pck_clk, pck_ready;
  logic [31:0] status_word;

  // synchronised reset copy used by everything below
  assign rst_n = rst_sync_q[1];
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // edge strobes from the second and third stages; stage 0 feeds stage 1 alone
  assign slow_tick = s_q.slow_s[1] & ~s_q.slow_s[2];
  assign main_tick = s_q.main_s[1] & ~s_q.main_s[2] & (s_q.osc_stable);
  // factor 0 or reference divider 0 means no PLL output
  assign pll_tick = s_q.pll_s[1] & ~s_q.pll_s[2] & (s_q.pll_cfg[26:16] != 11'd0) // [RULE17]
                    & (s_q.pll_cfg[7:0] != 8'd0); // [RULE14]
  assign wr = i_avs_write & ~s_q.ack;
  assign rd = i_avs_read & ~s_q.ack;
  // fall back to main clock while the PLL relocks
  assign mck_eff_src = (s_q.mck_src == CPM_SRC_PLL && !s_q.pll_locked) ? CPM_SRC_MAIN : s_q.mck_src; // [RULE24]

  assign status_word = {21'h0, pck_ready, 4'h0, mck_ready, s_q.pll_locked, 1'b0, s_q.osc_stable};

  // register decode, oscillator, frequency meter and PLL lock timer
  always_comb begin
    s_d = s_q;
    s_d.slow_s = {s_q.slow_s[1:0], i_slow_clk};
    s_d.main_s = {s_q.main_s[1:0], i_crystal_in};
    s_d.pll_s = {s_q.pll_s[1:0], i_pll_clk};
    s_d.ack = (i_avs_read | i_avs_write) & ~s_q.ack;
    if (wr) begin
      unique case (i_avs_address)
        CPM_SYS_SET_OFF: s_d.sys_en = s_q.sys_en | i_avs_writedata[11:0]; // [RULE27]
        CPM_SYS_CLR_OFF: s_d.sys_en = s_q.sys_en & ~i_avs_writedata[11:0]; // [RULE26]
        CPM_PER_SET_OFF: s_d.per_en = s_q.per_en | (i_avs_writedata & CPM_PER_IMPL); // [RULE4] [RULE5]
        CPM_PER_CLR_OFF: s_d.per_en = s_q.per_en & ~(i_avs_writedata & CPM_PER_IMPL); // [RULE6]
        CPM_OSC_CTRL_OFF: begin
          s_d.osc_on = i_avs_writedata[0];
          s_d.osc_skip = i_avs_writedata[1];
          s_d.osc_count = i_avs_writedata[15:8];
          s_d.osc_timer = {i_avs_writedata[15:8], 3'b000}; // [RULE11]
        end
        CPM_PLL_CFG_OFF: begin
          s_d.pll_cfg = {2'b00, i_avs_writedata[29:0]};
          if (i_avs_writedata[29:28] == CPM_USB_CLOCK_RATIO_RSV) begin
            s_d.pll_cfg[29:28] = s_q.pll_cfg[29:28]; // [RULE18]
          end
          s_d.pll_locked = 1'b0;
          s_d.lock_timer = {2'b00, i_avs_writedata[13:8]}; // [RULE15]
        end
        CPM_MCK_CFG_OFF: begin
          if (i_avs_writedata[1:0] != CPM_SRC_RSV) s_d.mck_src = i_avs_writedata[1:0]; // [RULE19] [RULE28]
          if (i_avs_writedata[4:2] != CPM_CLOCK_SCALER_CODE_RSV) s_d.mck_clock_scaler_code = i_avs_writedata[4:2]; // [RULE20] [RULE28]
        end
        default: ;
      endcase
      // each programmable output keeps its own configuration
      for (int k = 0; k < CPM_NUM_PCK; k++) begin
        if (i_avs_address == CPM_PCK0_OFF + 8'(4 * k)) begin
          if (i_avs_writedata[1:0] != CPM_SRC_RSV) s_d.pck_cfg[k][1:0] = i_avs_writedata[1:0]; // [RULE21] [RULE28]
          if (i_avs_writedata[4:2] != CPM_CLOCK_SCALER_CODE_RSV) s_d.pck_cfg[k][4:2] = i_avs_writedata[4:2]; // [RULE22] [RULE28]
        end
      end
    end
    // oscillator stable flag
    if (s_q.osc_skip) begin
      s_d.osc_stable = 1'b1; // [RULE9]
    end else if (!s_q.osc_on) begin
      s_d.osc_stable = 1'b0; // [RULE10]
    end else if (slow_tick && !s_q.osc_stable) begin
      if (s_q.osc_timer == 11'd0) s_d.osc_stable = 1'b1; // [RULE8]
      else s_d.osc_timer = s_q.osc_timer - 11'd1;
    end
    // frequency meter over a window of slow periods
    // valid drops in the same cycle as stable, never trailing it
    if (!s_q.osc_stable || !s_d.osc_stable) begin
      s_d.freq_valid = 1'b0; // [RULE13]
      s_d.win_cnt = '0;
      s_d.freq_acc = '0;
    end else begin
      if (main_tick) s_d.freq_acc = s_q.freq_acc + 16'd1;
      if (slow_tick) begin
        if (s_q.win_cnt == 5'(CPM_FREQ_WINDOW - 1)) begin
          s_d.freq_cnt = main_tick ? s_q.freq_acc + 16'd1 : s_q.freq_acc; // [RULE12]
          s_d.freq_valid = 1'b1; // [RULE13]
          s_d.freq_acc = '0;
          s_d.win_cnt = '0;
        end else begin
          s_d.win_cnt = s_q.win_cnt + 5'd1;
        end
      end
    end
    // PLL lock timer runs on slow clock after any configuration write
    // a deactivated PLL (factor 0, as after reset) never reports lock
    if (!(wr && i_avs_address == CPM_PLL_CFG_OFF) && !s_q.pll_locked && slow_tick
        && (s_q.pll_cfg[26:16] != 11'd0)) begin // [RULE17]
      if (s_q.lock_timer == 8'd0) s_d.pll_locked = 1'b1; // [RULE15]
      else s_d.lock_timer = s_q.lock_timer - 8'd1;
    end
    s_d.pll_ref = (s_d.pll_cfg[7:0] != 8'd0); // [RULE14]
    // read mux, answered one cycle after the request
    s_d.rdata = 32'h0;
    if (rd) begin
      unique case (i_avs_address)
        CPM_SYS_STATE_OFF: s_d.rdata = {20'h0, s_q.sys_en}; // [RULE1] [RULE2] [RULE3]
        CPM_PER_STATE_OFF: s_d.rdata = s_q.per_en & CPM_PER_IMPL; // [RULE7]
        CPM_OSC_CTRL_OFF: s_d.rdata = {16'h0, s_q.osc_count, 6'h0, s_q.osc_skip, s_q.osc_on};
        CPM_FREQ_OFF: s_d.rdata = {15'h0, s_q.freq_valid, s_q.freq_cnt};
        CPM_PLL_CFG_OFF: s_d.rdata = s_q.pll_cfg;
        CPM_MCK_CFG_OFF: s_d.rdata = {27'h0, s_q.mck_clock_scaler_code, s_q.mck_src};
        CPM_PCK0_OFF: s_d.rdata = {27'h0, s_q.pck_cfg[0]};
        CPM_PCK1_OFF: s_d.rdata = {27'h0, s_q.pck_cfg[1]};
        CPM_PCK2_OFF: s_d.rdata = {27'h0, s_q.pck_cfg[2]};
        CPM_STATUS_OFF: s_d.rdata = status_word;
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  // all block state except the reset synchroniser and the clock dividers
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.slow_s <= '0;
      s_q.main_s <= '0;
      s_q.pll_s <= '0;
      s_q.sys_en <= CPM_SYS_RST;
      s_q.per_en <= '0;
      s_q.osc_count <= '0;
      s_q.osc_on <= 1'b0;
      s_q.osc_skip <= 1'b0;
      s_q.osc_stable <= 1'b0;
      s_q.osc_timer <= '0;
      s_q.win_cnt <= '0;
      s_q.freq_acc <= '0;
      s_q.freq_cnt <= '0;
      s_q.freq_valid <= 1'b0;
      s_q.pll_cfg <= CPM_PLL_RST;
      s_q.lock_timer <= '0;
      s_q.pll_locked <= 1'b0;
      s_q.pll_ref <= 1'b0;
      s_q.mck_src <= CPM_SRC_SLOW;
      s_q.mck_clock_scaler_code <= 3'h0;
      s_q.pck_cfg <= '0;
      s_q.ack <= 1'b0;
      s_q.rdata <= '0;
    end else begin
      s_q.slow_s <= s_d.slow_s;
      s_q.main_s <= s_d.main_s;
      s_q.pll_s <= s_d.pll_s;
      s_q.sys_en <= s_d.sys_en;
      s_q.per_en <= s_d.per_en;
      s_q.osc_count <= s_d.osc_count;
      s_q.osc_on <= s_d.osc_on;
      s_q.osc_skip <= s_d.osc_skip;
      s_q.osc_stable <= s_d.osc_stable;
      s_q.osc_timer <= s_d.osc_timer;
      s_q.win_cnt <= s_d.win_cnt;
      s_q.freq_acc <= s_d.freq_acc;
      s_q.freq_cnt <= s_d.freq_cnt;
      s_q.freq_valid <= s_d.freq_valid;
      s_q.pll_cfg <= s_d.pll_cfg;
      s_q.lock_timer <= s_d.lock_timer;
      s_q.pll_locked <= s_d.pll_locked;
      s_q.pll_ref <= s_d.pll_ref;
      s_q.mck_src <= s_d.mck_src;
      s_q.mck_clock_scaler_code <= s_d.mck_clock_scaler_code;
      s_q.pck_cfg <= s_d.pck_cfg;
      s_q.ack <= s_d.ack;
      s_q.rdata <= s_d.rdata;
    end
  end

  // master clock path; ready drops on every source or prescaler change
  cpm_clk_div u_mck (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_slow_tick(slow_tick),
    .i_main_tick(main_tick),
    .i_pll_tick(pll_tick),
    .i_src(mck_eff_src),
    .i_clock_scaler_code(s_q.mck_clock_scaler_code),
    .i_enable(1'b1),
    .o_clk(mck_clk),
    .o_ready(mck_ready)
  ); // [RULE23]

  // programmable outputs, one divider each
  for (genvar g = 0; g < CPM_NUM_PCK; g++) begin : g_pck
    cpm_clk_div u_pck (
      .i_core_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_slow_tick(slow_tick),
      .i_main_tick(main_tick),
      .i_pll_tick(pll_tick),
      .i_src(s_q.pck_cfg[g][1:0]),
      .i_clock_scaler_code(s_q.pck_cfg[g][4:2]),
      .i_enable(s_q.sys_en[CPM_PCK_LSB + g]),
      .o_clk(pck_clk[g]),
      .o_ready(pck_ready[g])
    ); // [RULE25]
  end

  // outputs straight from flip-flops
  assign o_avs_readdata = s_q.rdata;
  assign o_avs_waitrequest = ~s_q.ack;
  assign o_cpu_clk_en = s_q.sys_en[CPM_CPU_BIT]; // [RULE1]
  assign o_usb_clk_en = s_q.sys_en[CPM_USB_BIT]; // [RULE2]
  assign o_periph_clk_en = s_q.per_en;
  assign o_master_clk = mck_clk;
  assign o_ext_clock_out = pck_clk; // [RULE3]
  assign o_pll_ref_en = s_q.pll_ref; // [RULE14]

  // guards
  a_cpu_clear_stops: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (wr && i_avs_address == CPM_SYS_CLR_OFF && i_avs_writedata[0]) |=> !o_cpu_clk_en) // [RULE26]
    else $error("cpu clock still on after clear");
  a_periph_low_bits: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    o_periph_clk_en[1:0] == 2'b00) // [RULE5]
    else $error("unimplemented peripheral clock enabled");
  a_per_set_takes: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (wr && i_avs_address == CPM_PER_SET_OFF) |=> ((o_periph_clk_en & $past(i_avs_writedata) & CPM_PER_IMPL)
    == ($past(i_avs_writedata) & CPM_PER_IMPL))) // [RULE4]
    else $error("peripheral set write lost");
  a_per_clr_takes: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (wr && i_avs_address == CPM_PER_CLR_OFF) |=> ((o_periph_clk_en & $past(i_avs_writedata)) == 32'h0)) // [RULE6]
    else $error("peripheral clear write lost");
  a_skip_stable: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_q.osc_skip |=> s_q.osc_stable) // [RULE9]
    else $error("bypass did not set stable");
  a_off_unstable: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (!s_q.osc_skip && !s_q.osc_on) |=> !s_q.osc_stable) // [RULE10]
    else $error("stable flag kept with oscillator off");
  a_freq_valid_off: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_q.freq_valid |-> s_q.osc_stable) // [RULE13]
    else $error("frequency valid without oscillator");
  a_pll_write_unlocks: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (wr && i_avs_address == CPM_PLL_CFG_OFF && i_avs_writedata[13:8] != 6'h0) |=> !s_q.pll_locked [*2]) // [RULE15]
    else $error("lock not dropped after PLL write");
  a_mck_fallback: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (!s_q.pll_locked) |-> (mck_eff_src != CPM_SRC_PLL)) // [RULE24]
    else $error("master on unlocked PLL");
  a_mck_change_drops: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    ($changed(mck_eff_src) || $changed(s_q.mck_clock_scaler_code)) |=> !mck_ready) // [RULE23]
    else $error("master ready kept over change");
  a_rsv_src_kept: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_q.mck_src != CPM_SRC_RSV && s_q.mck_clock_scaler_code != CPM_CLOCK_SCALER_CODE_RSV) // [RULE28]
    else $error("reserved master code stored");
  a_bus_answer: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_avs_read && o_avs_waitrequest) |=> !o_avs_waitrequest) // [RULE27]
    else $error("bus answer late");
  c_osc_stable: cover property (@(posedge i_core_clk) disable iff (!rst_n) s_q.osc_on && $rose(s_q.osc_stable));
  c_pll_lock: cover property (@(posedge i_core_clk) disable iff (!rst_n) $rose(s_q.pll_locked));
  c_mck_ready: cover property (@(posedge i_core_clk) disable iff (!rst_n) $rose(mck_ready));
  c_freq_valid: cover property (@(posedge i_core_clk) disable iff (!rst_n) $rose(s_q.freq_valid));
endmodule
`default_nettype wire
